// ===== hdl/rcs_reset_cause.sv
// Purpose: Reset and wake cause flags, restart address and supply status
// Assumes: Detector inputs are asynchronous; core signals share i_clk
// Notes:   Simultaneous events resolve power-on, brown-out, watchdog, pin, wake
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause
	import rcs_pkg::*;
(
	// Clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_resetn,
	// Detectors and pins
	input  wire logic                i_por_det,
	input  wire logic                i_bor_det,
	input  wire logic                i_wdt_timeout,
	input  wire logic                i_ext_reset_pin_n,
	input  wire logic                i_int_wake,
	input  wire logic                i_supply_ok,
	input  wire logic                i_adc_ref_ok,
	// Core status
	input  wire logic                i_sleeping,
	input  wire logic                i_gie,
	input  wire logic [RCS_PC_W-1:0] i_next_pc,
	input  wire logic                i_instr_done,
	// Register port
	input  wire logic [RCS_AW-1:0]   i_addr,
	input  wire logic [RCS_DW-1:0]   i_wdata,
	input  wire logic                i_we,
	input  wire logic                i_re,
	output logic      [RCS_DW-1:0]   o_rdata,
	// Restart and vector
	output var rcs_restart_s         o_restart,
	output logic                     o_vector_take,
	output logic      [RCS_PC_W-1:0] o_vector_addr,
	output logic      [RCS_PC_W-1:0] o_push_addr,
	// Interrupt
	output logic                     o_irq
);

	// ****************************************
	// Synchronisers and edges
	// ****************************************
	logic [6:0]     sync_s;
	logic [6:1]     prev_q;
	rcs_event_s     raw_ev;
	rcs_event_s     sel;
	logic           sup_drop;
	logic           any_ev;
	logic           any_reset;
	logic           ok_s;
	logic           adc_s;

	rcs_sync2 #(
		.W(7)
	) u_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  ({i_por_det, i_bor_det, i_wdt_timeout, i_ext_reset_pin_n,
		            i_int_wake, i_supply_ok, i_adc_ref_ok}),
		.o_sync   (sync_s)
	);

	assign ok_s  = sync_s[1];
	assign adc_s = sync_s[0];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= sync_s[6:1];
		end
	end

	always_comb begin
		raw_ev.por   = sync_s[6] & ~prev_q[6];
		raw_ev.bor   = sync_s[5] & ~prev_q[5];
		raw_ev.wdt   = sync_s[4] & ~prev_q[4];
		raw_ev.ext   = ~sync_s[3] & prev_q[3];
		raw_ev.iwake = sync_s[2] & ~prev_q[2] & i_sleeping;
		sel.por      = raw_ev.por;
		sel.bor      = raw_ev.bor & ~raw_ev.por;
		sel.wdt      = raw_ev.wdt & ~raw_ev.por & ~raw_ev.bor;
		sel.ext      = raw_ev.ext & ~(raw_ev.por | raw_ev.bor | raw_ev.wdt);
		sel.iwake    = raw_ev.iwake & ~(raw_ev.por | raw_ev.bor | raw_ev.wdt | raw_ev.ext);
	end

	assign sup_drop  = ~sync_s[1] & prev_q[1];
	assign any_ev    = |sel;
	assign any_reset = sel.por | sel.bor | (sel.wdt & ~i_sleeping) | sel.ext;

	// ****************************************
	// Write decode
	// ****************************************
	logic wr_pwr;
	logic wr_st;
	logic wr_isr;
	logic wr_imk;

	assign wr_pwr = i_we & rcs_hit(i_addr, RCS_OFF_PWR_CTRL);
	assign wr_st  = i_we & rcs_hit(i_addr, RCS_OFF_PROC_STAT);
	assign wr_isr = i_we & rcs_hit(i_addr, RCS_OFF_IRQ_STAT);
	assign wr_imk = i_we & rcs_hit(i_addr, RCS_OFF_IRQ_MASK);

	// ****************************************
	// Processor status flags
	// ****************************************
	logic       to_q;
	logic       pd_q;
	logic [2:0] st_hi_q;
	logic [2:0] st_lo_q;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			to_q <= RCS_TO_RST;
			pd_q <= RCS_PD_RST;
		end else if (sel.por | sel.bor) begin
			to_q <= 1'h1;
			pd_q <= 1'h1;
		end else if (sel.wdt) begin
			to_q <= 1'h0;
			if (i_sleeping) begin
				pd_q <= 1'h0;
			end
		end else if (sel.ext & i_sleeping) begin
			to_q <= 1'h1;
			pd_q <= 1'h0;
		end else if (sel.iwake) begin
			to_q <= 1'h1;
			pd_q <= 1'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_hi_q <= RCS_ST_HI_RST;
		end else if (any_reset) begin
			st_hi_q <= 3'h0;
		end else if (wr_st) begin
			st_hi_q <= i_wdata[RCS_ST_HI_LSB +: 3];
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_lo_q <= RCS_ST_LO_RST;
		end else if (sel.por | sel.bor) begin
			st_lo_q <= RCS_ST_LO_RST;
		end else if (wr_st) begin
			st_lo_q <= i_wdata[RCS_ST_LO_LSB +: 3];
		end
	end

	// ****************************************
	// Power control flags
	// ****************************************
	logic por_flag_q;
	logic bor_flag_q;
	logic hist_q;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			por_flag_q <= RCS_POR_FLAG_RST;
		end else if (sel.por) begin
			por_flag_q <= 1'h0;
		end else if (wr_pwr) begin
			por_flag_q <= i_wdata[RCS_PWR_POR];
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bor_flag_q <= RCS_BOR_FLAG_RST;
		end else if (sel.bor) begin
			bor_flag_q <= 1'h0;
		end else if (wr_pwr) begin
			bor_flag_q <= i_wdata[RCS_PWR_BOR];
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hist_q <= RCS_HIST_RST;
		end else if (!ok_s) begin
			hist_q <= 1'h0;
		end else if (wr_pwr) begin
			hist_q <= i_wdata[RCS_PWR_HIST];
		end
	end

	// ****************************************
	// Restart request
	// ****************************************
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_restart <= '0;
		end else begin
			o_restart.valid     <= any_ev;
			o_restart.reg_reset <= any_reset;
			o_restart.resume    <= any_ev & ~any_reset;
			if (any_reset) begin
				o_restart.addr <= RCS_RESET_VEC;
			end else if (any_ev) begin
				o_restart.addr <= i_next_pc;
			end
		end
	end

	// ****************************************
	// Interrupt vector after wake
	// ****************************************
	rcs_vec_state_e vs_q;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			vs_q          <= RCS_VS_IDLE;
			o_vector_take <= 1'h0;
			o_push_addr   <= '0;
		end else begin
			o_vector_take <= 1'h0;
			case (vs_q)
				RCS_VS_IDLE: begin
					if (sel.iwake & i_gie) begin
						vs_q        <= RCS_VS_WAIT;
						o_push_addr <= RCS_PC_W'(i_next_pc + 1'b1);
					end
				end
				RCS_VS_WAIT: begin
					if (any_reset) begin
						vs_q <= RCS_VS_IDLE;
					end else if (i_instr_done) begin
						vs_q          <= RCS_VS_IDLE;
						o_vector_take <= 1'h1;
					end
				end
				default: begin
					vs_q <= RCS_VS_IDLE;
				end
			endcase
		end
	end

	assign o_vector_addr = RCS_INT_VEC;

	// ****************************************
	// Interrupt status
	// ****************************************
	logic [RCS_IRQ_N-1:0] irq_set;
	logic [RCS_IRQ_N-1:0] irq_status;
	logic [RCS_IRQ_N-1:0] irq_mask;

	always_comb begin
		irq_set                   = '0;
		irq_set[RCS_IRQ_POR]      = sel.por;
		irq_set[RCS_IRQ_BOR]      = sel.bor;
		irq_set[RCS_IRQ_WDT_RST]  = sel.wdt & ~i_sleeping;
		irq_set[RCS_IRQ_WDT_WAKE] = sel.wdt & i_sleeping;
		irq_set[RCS_IRQ_EXT_RST]  = sel.ext;
		irq_set[RCS_IRQ_INT_WAKE] = sel.iwake;
		irq_set[RCS_IRQ_SUP_DROP] = sup_drop;
	end

	rcs_irq #(
		.N(RCS_IRQ_N)
	) u_irq (
		.i_clk     (i_clk),
		.i_resetn  (i_resetn),
		.i_set     (irq_set),
		.i_clr_we  (wr_isr),
		.i_mask_we (wr_imk),
		.i_wdata   (i_wdata[RCS_IRQ_N-1:0]),
		.o_status  (irq_status),
		.o_mask    (irq_mask),
		.o_irq     (o_irq)
	);

	// ****************************************
	// Read path
	// ****************************************
	logic [RCS_DW-1:0] pwr_rd;
	logic [RCS_DW-1:0] st_rd;
	logic [RCS_DW-1:0] rd_d;

	always_comb begin
		pwr_rd                  = '0;
		pwr_rd[RCS_PWR_ADC_REF] = adc_s;
		pwr_rd[RCS_PWR_HIST]    = hist_q;
		pwr_rd[RCS_PWR_OK]      = ok_s;
		pwr_rd[RCS_PWR_POR]     = por_flag_q;
		pwr_rd[RCS_PWR_BOR]     = bor_flag_q;
		st_rd                   = '0;
		st_rd[RCS_ST_HI_LSB +: 3] = st_hi_q;
		st_rd[RCS_ST_TO]        = to_q;
		st_rd[RCS_ST_PD]        = pd_q;
		st_rd[RCS_ST_LO_LSB +: 3] = st_lo_q;
		rd_d                    = '0;
		if (rcs_hit(i_addr, RCS_OFF_PWR_CTRL)) begin
			rd_d = pwr_rd;
		end else if (rcs_hit(i_addr, RCS_OFF_PROC_STAT)) begin
			rd_d = st_rd;
		end else if (rcs_hit(i_addr, RCS_OFF_IRQ_STAT)) begin
			rd_d = {1'b0, irq_status};
		end else if (rcs_hit(i_addr, RCS_OFF_IRQ_MASK)) begin
			rd_d = {1'b0, irq_mask};
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= '0;
		end else if (i_re) begin
			o_rdata <= rd_d;
		end else begin
			o_rdata <= '0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	logic rd_pwr;
	logic wait_done;
	logic wake_gie;

	assign rd_pwr    = i_re & rcs_hit(i_addr, RCS_OFF_PWR_CTRL);
	assign wait_done = (vs_q == RCS_VS_WAIT) & i_instr_done & ~any_reset;
	assign wake_gie  = sel.iwake & i_gie & (vs_q == RCS_VS_IDLE);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	AST_POR_STATE: assert property (
		sel.por |=> !por_flag_q && to_q && pd_q && st_hi_q == 3'h0
		&& o_restart.valid && o_restart.addr == RCS_RESET_VEC)
		else $error("power-on state wrong");
	AST_BOR_STATE: assert property (
		sel.bor |=> !bor_flag_q && to_q && pd_q && por_flag_q == $past(por_flag_q)
		&& o_restart.reg_reset && o_restart.addr == RCS_RESET_VEC)
		else $error("brown-out state wrong");
	AST_WDT_RUN: assert property (
		sel.wdt && !i_sleeping |=> !to_q && pd_q == $past(pd_q)
		&& o_restart.reg_reset && o_restart.addr == RCS_RESET_VEC)
		else $error("watchdog reset wrong");
	AST_WDT_SLEEP: assert property (
		sel.wdt && i_sleeping |=> !to_q && !pd_q && o_restart.resume
		&& !o_restart.reg_reset && o_restart.addr == $past(i_next_pc))
		else $error("watchdog wake wrong");
	AST_INT_WAKE: assert property (
		sel.iwake |=> to_q && !pd_q && o_restart.resume && !o_restart.reg_reset
		&& o_restart.addr == $past(i_next_pc))
		else $error("interrupt wake wrong");
	AST_VEC_WAIT: assert property (
		wake_gie |=> vs_q == RCS_VS_WAIT && !o_vector_take)
		else $error("vector wait missing");
	AST_VEC_TAKE: assert property (
		wait_done |=> o_vector_take ##1 !o_vector_take)
		else $error("vector take wrong");
	AST_EXT_RUN: assert property (
		sel.ext && !i_sleeping |=> $stable(to_q) && $stable(pd_q) && $stable(por_flag_q)
		&& $stable(bor_flag_q) && o_restart.addr == RCS_RESET_VEC)
		else $error("pin reset changed flags");
	AST_EXT_SLEEP: assert property (
		sel.ext && i_sleeping |=> to_q && !pd_q && $stable(por_flag_q)
		&& o_restart.reg_reset && o_restart.addr == RCS_RESET_VEC)
		else $error("pin reset in sleep wrong");
	AST_ADC_REF: assert property (
		rd_pwr |=> o_rdata[RCS_PWR_ADC_REF] == $past(adc_s))
		else $error("reference bit wrong");
	AST_HIST: assert property (
		!ok_s |=> !hist_q)
		else $error("history not cleared");
	AST_SUP_OK: assert property (
		rd_pwr |=> o_rdata[RCS_PWR_OK] == $past(ok_s))
		else $error("regulation bit wrong");
	AST_POR_SET: assert property (
		wr_pwr && i_wdata[RCS_PWR_POR] && !sel.por |=> por_flag_q)
		else $error("power-on flag not set");
	AST_BOR_SET: assert property (
		wr_pwr && i_wdata[RCS_PWR_BOR] && !sel.bor |=> bor_flag_q)
		else $error("brown-out flag not set");
	AST_UNIMPL: assert property (
		rd_pwr |=> o_rdata[6:4] == 3'h0)
		else $error("unused bits not zero");

endmodule
`default_nettype wire

// ===== hdl/rcs_pkg.sv
// Purpose: Shared constants and types for the reset cause status logic
// Assumes: 8-bit register port, 13-bit program counter
// Notes:   Offsets are byte addresses on the plain register port
package rcs_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int RCS_AW   = 8;
	localparam int RCS_DW   = 8;
	localparam int RCS_PC_W = 13;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [RCS_AW-1:0] RCS_OFF_PWR_CTRL  = 8'h00;
	localparam logic [RCS_AW-1:0] RCS_OFF_PROC_STAT = 8'h01;
	localparam logic [RCS_AW-1:0] RCS_OFF_IRQ_STAT  = 8'h02;
	localparam logic [RCS_AW-1:0] RCS_OFF_IRQ_MASK  = 8'h03;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int RCS_PWR_ADC_REF = 7;
	localparam int RCS_PWR_HIST    = 3;
	localparam int RCS_PWR_OK      = 2;
	localparam int RCS_PWR_POR     = 1;
	localparam int RCS_PWR_BOR     = 0;
	localparam int RCS_ST_HI_LSB   = 5;
	localparam int RCS_ST_TO       = 4;
	localparam int RCS_ST_PD       = 3;
	localparam int RCS_ST_LO_LSB   = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [2:0] RCS_ST_HI_RST    = 3'h0;
	localparam logic [2:0] RCS_ST_LO_RST    = 3'h0;
	localparam logic       RCS_TO_RST       = 1'h1;
	localparam logic       RCS_PD_RST       = 1'h1;
	localparam logic       RCS_POR_FLAG_RST = 1'h0;
	localparam logic       RCS_BOR_FLAG_RST = 1'h0;
	localparam logic       RCS_HIST_RST     = 1'h0;

	// ****************************************
	// Restart addresses
	// ****************************************
	localparam logic [RCS_PC_W-1:0] RCS_RESET_VEC = 13'h0000;
	localparam logic [RCS_PC_W-1:0] RCS_INT_VEC   = 13'h0004;

	// ****************************************
	// Interrupt status bits
	// ****************************************
	localparam int RCS_IRQ_N        = 7;
	localparam int RCS_IRQ_POR      = 0;
	localparam int RCS_IRQ_BOR      = 1;
	localparam int RCS_IRQ_WDT_RST  = 2;
	localparam int RCS_IRQ_WDT_WAKE = 3;
	localparam int RCS_IRQ_EXT_RST  = 4;
	localparam int RCS_IRQ_INT_WAKE = 5;
	localparam int RCS_IRQ_SUP_DROP = 6;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic por;
		logic bor;
		logic wdt;
		logic ext;
		logic iwake;
	} rcs_event_s;

	typedef struct packed {
		logic                valid;
		logic                reg_reset;
		logic                resume;
		logic [RCS_PC_W-1:0] addr;
	} rcs_restart_s;

	typedef enum logic [0:0] {
		RCS_VS_IDLE,
		RCS_VS_WAIT
	} rcs_vec_state_e;

	function automatic logic rcs_hit(input logic [RCS_AW-1:0] a, input logic [RCS_AW-1:0] off);
		return a == off;
	endfunction

endpackage

// ===== hdl/rcs_sync2.sv
// Purpose: Two flip-flop synchroniser for asynchronous levels
// Assumes: Inputs change slowly against the core clock
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ps
`default_nettype none
module rcs_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	// Levels
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	initial begin
		if (W < 1) begin
			$error("rcs_sync2: W must be at least 1");
		end
	end

	logic [W-1:0] meta_q;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ===== hdl/rcs_irq.sv
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Write-one-to-clear on status, plain write on mask
// Notes:   A set in the clear cycle wins
`timescale 1ns/1ps
`default_nettype none
module rcs_irq #(
	parameter int N = 7
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	// Events
	input  wire logic [N-1:0] i_set,
	// Software access
	input  wire logic         i_clr_we,
	input  wire logic         i_mask_we,
	input  wire logic [N-1:0] i_wdata,
	// State
	output logic      [N-1:0] o_status,
	output logic      [N-1:0] o_mask,
	output logic              o_irq
);

	initial begin
		if (N < 1 || N > 8) begin
			$error("rcs_irq: N must be 1 to 8");
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_status <= '0;
		end else begin
			o_status <= (o_status & ~(i_clr_we ? i_wdata : '0)) | i_set;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_mask <= '0;
		end else if (i_mask_we) begin
			o_mask <= i_wdata;
		end
	end

	assign o_irq = |(o_status & o_mask);

endmodule
`default_nettype wire

// ===== tb/rcs_reset_cause_tb.sv
// Purpose: Self-checking bench for the reset cause status logic
// Assumes: 20 MHz clock, register port with read data one cycle later
// Notes:   Events are driven as async pulses and seen after the synchroniser
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rcs_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic                i_clk;
	logic                i_resetn;
	logic                i_por_det;
	logic                i_bor_det;
	logic                i_wdt_timeout;
	logic                i_ext_reset_pin_n;
	logic                i_int_wake;
	logic                i_supply_ok;
	logic                i_adc_ref_ok;
	logic                i_sleeping;
	logic                i_gie;
	logic [RCS_PC_W-1:0] i_next_pc;
	logic                i_instr_done;
	logic [RCS_AW-1:0]   i_addr;
	logic [RCS_DW-1:0]   i_wdata;
	logic                i_we;
	logic                i_re;
	logic [RCS_DW-1:0]   o_rdata;
	rcs_restart_s        o_restart;
	logic                o_vector_take;
	logic [RCS_PC_W-1:0] o_vector_addr;
	logic [RCS_PC_W-1:0] o_push_addr;
	logic                o_irq;
	rcs_restart_s        rs;
	logic                rs_ok;
	int                  error_cnt;
	int                  tests_run;

	rcs_reset_cause dut (
		.i_clk             (i_clk),
		.i_resetn          (i_resetn),
		.i_por_det         (i_por_det),
		.i_bor_det         (i_bor_det),
		.i_wdt_timeout     (i_wdt_timeout),
		.i_ext_reset_pin_n (i_ext_reset_pin_n),
		.i_int_wake        (i_int_wake),
		.i_supply_ok       (i_supply_ok),
		.i_adc_ref_ok      (i_adc_ref_ok),
		.i_sleeping        (i_sleeping),
		.i_gie             (i_gie),
		.i_next_pc         (i_next_pc),
		.i_instr_done      (i_instr_done),
		.i_addr            (i_addr),
		.i_wdata           (i_wdata),
		.i_we              (i_we),
		.i_re              (i_re),
		.o_rdata           (o_rdata),
		.o_restart         (o_restart),
		.o_vector_take     (o_vector_take),
		.o_vector_addr     (o_vector_addr),
		.o_push_addr       (o_push_addr),
		.o_irq             (o_irq)
	);

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	initial begin
		#(50 * 4000);
		error_cnt++;
		results();
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_we    <= 1'b1;
		@(posedge i_clk);
		i_we    <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_re   <= 1'b1;
		@(posedge i_clk);
		i_re   <= 1'b0;
		#1;
		chk({8'h00, o_rdata}, {8'h00, exp});
	endtask

	// Fire one event: 0 power-on, 1 brown-out, 2 watchdog, 3 pin, 4 wake
	task automatic evt(input int k);
		rs_ok = 1'b0;
		@(posedge i_clk);
		case (k)
			0: i_por_det <= 1'b1;
			1: i_bor_det <= 1'b1;
			2: i_wdt_timeout <= 1'b1;
			3: i_ext_reset_pin_n <= 1'b0;
			default: i_int_wake <= 1'b1;
		endcase
		for (int i = 0; i < 8 && !rs_ok; i++) begin
			@(posedge i_clk);
			#1;
			if (o_restart.valid === 1'b1) begin
				rs    = o_restart;
				rs_ok = 1'b1;
			end
		end
		@(posedge i_clk);
		i_por_det         <= 1'b0;
		i_bor_det         <= 1'b0;
		i_wdt_timeout     <= 1'b0;
		i_ext_reset_pin_n <= 1'b1;
		i_int_wake        <= 1'b0;
		repeat (4) @(posedge i_clk);
	endtask

	task automatic rst_chk();
		chk({15'h0, rs_ok}, 16'h1);
		chk({rs.reg_reset, rs.resume, 1'b0, rs.addr}, {2'b10, 1'b0, RCS_RESET_VEC});
	endtask

	task automatic res_chk();
		chk({15'h0, rs_ok}, 16'h1);
		chk({rs.reg_reset, rs.resume, 1'b0, rs.addr}, {2'b01, 1'b0, i_next_pc});
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		error_cnt = 0;
		tests_run = 0;
		i_resetn = 1'b0;
		i_por_det = 1'b0;
		i_bor_det = 1'b0;
		i_wdt_timeout = 1'b0;
		i_ext_reset_pin_n = 1'b1;
		i_int_wake = 1'b0;
		i_supply_ok = 1'b1;
		i_adc_ref_ok = 1'b1;
		i_sleeping = 1'b0;
		i_gie = 1'b0;
		i_next_pc = 13'h0123;
		i_instr_done = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_we = 1'b0;
		i_re = 1'b0;
		repeat (12) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clk);
		rdc(8'h00, 8'h84);
		rdc(8'h01, 8'h18);
		rdc(8'h10, 8'h00);
		wr(8'h00, 8'hff);
		rdc(8'h00, 8'h8f);
		wr(8'h03, 8'h7f);
		rdc(8'h03, 8'h7f);
		@(posedge i_clk);
		i_supply_ok <= 1'b0;
		repeat (4) @(posedge i_clk);
		rdc(8'h00, 8'h83);
		wr(8'h00, 8'hf7);
		rdc(8'h00, 8'h83);
		@(posedge i_clk);
		i_supply_ok  <= 1'b1;
		i_adc_ref_ok <= 1'b0;
		repeat (4) @(posedge i_clk);
		rdc(8'h00, 8'h07);
		wr(8'h00, 8'h0f);
		@(posedge i_clk);
		i_adc_ref_ok <= 1'b1;
		repeat (4) @(posedge i_clk);
		rdc(8'h00, 8'h8f);
		wr(8'h01, 8'hff);
		rdc(8'h01, 8'hff);
		evt(0);
		rst_chk();
		rdc(8'h00, 8'h8d);
		rdc(8'h01, 8'h18);
		wr(8'h00, 8'h8f);
		wr(8'h01, 8'hff);
		evt(1);
		rst_chk();
		rdc(8'h00, 8'h8e);
		rdc(8'h01, 8'h18);
		wr(8'h00, 8'h8f);
		wr(8'h01, 8'hff);
		evt(2);
		rst_chk();
		rdc(8'h01, 8'h0f);
		wr(8'h01, 8'hff);
		i_sleeping <= 1'b1;
		evt(3);
		rst_chk();
		rdc(8'h01, 8'h17);
		wr(8'h01, 8'hff);
		evt(2);
		res_chk();
		rdc(8'h01, 8'he7);
		i_sleeping <= 1'b0;
		evt(3);
		rst_chk();
		rdc(8'h01, 8'h07);
		rdc(8'h00, 8'h8f);
		evt(4);
		chk({15'h0, rs_ok}, 16'h0);
		i_sleeping <= 1'b1;
		evt(4);
		res_chk();
		rdc(8'h01, 8'h17);
		i_gie <= 1'b1;
		evt(4);
		res_chk();
		chk({15'h0, o_vector_take}, 16'h0);
		i_sleeping <= 1'b0;
		i_instr_done <= 1'b1;
		@(posedge i_clk);
		i_instr_done <= 1'b0;
		#1;
		chk({15'h0, o_vector_take}, 16'h1);
		chk({3'h0, o_push_addr}, {3'h0, i_next_pc + 13'h1});
		chk({3'h0, o_vector_addr}, {3'h0, RCS_INT_VEC});
		@(posedge i_clk);
		#1;
		chk({15'h0, o_vector_take}, 16'h0);
		rdc(8'h02, 8'h7f);
		chk({15'h0, o_irq}, 16'h1);
		wr(8'h03, 8'h00);
		#1;
		chk({15'h0, o_irq}, 16'h0);
		wr(8'h03, 8'h7f);
		wr(8'h02, 8'h7f);
		rdc(8'h02, 8'h00);
		chk({15'h0, o_irq}, 16'h0);
		results();
	end

endmodule
`default_nettype wire
